// *** dpt_ctrl.sv ***
// Controller end: offset supply, default offsets and handset reports
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "dpt_defines.svh"

module dpt_ctrl
  import dpt_pkg::*;
(
  input wire logic REF_CLK_I, // System clock
  input wire logic RESET_I, // Synchronous reset, active high
  dpt_if.ctrl LINK, // Offsets to the base station end
  input wire logic [7:0] ADDR_I, // Register byte address
  input wire logic [31:0] WDATA_I, // Write data
  input wire logic WR_I, // Write strobe
  input wire logic RD_I, // Read strobe
  output logic [31:0] RDATA_O, // Read data, cycle after RD_I
  output logic [9:0] DOFF_FDD_O, // Default offset, 512-chip steps
  output logic [2:0] DOFF_TDD_O, // Default offset, frames
  output logic DOFF_VALID_O // Default offset sent, one cycle
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpt_ctrl_s st_ff;
  dpt_ctrl_s nxt_st;

  logic [7:0] sfn_diff;
  logic [7:0] cfn_diff;
  logic [15:0] rx_diff;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Measurement arithmetic
  // ----------------------------------------------------------------
  assign sfn_diff = st_ff.cell_sfn[7:0] - st_ff.ref_sfn[7:0];
  assign cfn_diff = st_ff.cfn - st_ff.cell_sfn[7:0];

  // Chip difference folded back into one frame
  always_comb begin
    if (st_ff.cell_rx >= st_ff.ref_rx) begin
      rx_diff = st_ff.cell_rx - st_ff.ref_rx;
    end else begin
      rx_diff = st_ff.cell_rx + `DPT_FRAME_CHIPS - st_ff.ref_rx;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (ADDR_I)
      `DPT_REG_FO: rd_word = {24'h00_0000, st_ff.fo};
      `DPT_REG_CO: rd_word = {16'h0000, st_ff.co};
      `DPT_REG_DOFF_FDD: rd_word = {22'h00_0000, st_ff.doff_fdd};
      `DPT_REG_DOFF_TDD: rd_word = {29'h0000_0000, st_ff.doff_tdd};
      `DPT_REG_MEAS: rd_word = {27'h000_0000, st_ff.isref, st_ff.mreq, st_ff.mcase};
      `DPT_REG_REF_SFN: rd_word = {20'h0_0000, st_ff.ref_sfn};
      `DPT_REG_CELL_SFN: rd_word = {20'h0_0000, st_ff.cell_sfn};
      `DPT_REG_CFN: rd_word = {24'h00_0000, st_ff.cfn};
      `DPT_REG_REF_RX: rd_word = {16'h0000, st_ff.ref_rx};
      `DPT_REG_CELL_RX: rd_word = {16'h0000, st_ff.cell_rx};
      `DPT_REG_REPORT: rd_word = {st_ff.tm, 7'h00, st_ff.off_valid, st_ff.off};
      `DPT_REG_STATUS: rd_word = {30'h0000_0000, LINK.cfg_done, LINK.cfg_err};
      `DPT_REG_POS: rd_word = {8'h00, LINK.pos};
      default: rd_word = `DPT_RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cfg_valid = 1'b0;
    nxt_st.doff_valid = 1'b0;
    nxt_st.rdata = RD_I ? rd_word : `DPT_RST_WORD;
    if (WR_I) begin
      case (ADDR_I)
        `DPT_REG_CTRL: begin
          nxt_st.cfg_valid = WDATA_I[`DPT_CTRL_SEND];
          nxt_st.doff_valid = WDATA_I[`DPT_CTRL_DCH];
          if (WDATA_I[`DPT_CTRL_EVAL]) begin
            nxt_st.tm = `DPT_RST_HALF;
            nxt_st.off = `DPT_RST_BYTE;
            // Frame offset only when the network asked for it
            nxt_st.off_valid = st_ff.mreq;
            case (st_ff.mcase)
              DPT_CASE_SINGLE, DPT_CASE_IRAT_ONE: begin
                nxt_st.off = `DPT_RST_BYTE;
                nxt_st.tm = `DPT_RST_HALF;
              end
              DPT_CASE_MULTI, DPT_CASE_IRAT_MULTI: begin
                // Reference is the uplink cell or one the handset picked
                if (!st_ff.isref) begin
                  nxt_st.off = sfn_diff;
                  nxt_st.tm = rx_diff;
                end
              end
              DPT_CASE_ADD: begin
                nxt_st.off = cfn_diff;
                nxt_st.tm = rx_diff;
              end
              default: begin
                nxt_st.off_valid = 1'b0;
              end
            endcase
          end
        end
        `DPT_REG_FO: nxt_st.fo = WDATA_I[7:0];
        `DPT_REG_CO: nxt_st.co = WDATA_I[15:0];
        `DPT_REG_DOFF_FDD: begin
          if (WDATA_I[9:0] <= `DPT_DOFF_FDD_MAX && WDATA_I[31:10] == 22'h00_0000) begin
            nxt_st.doff_fdd = WDATA_I[9:0];
          end
        end
        `DPT_REG_DOFF_TDD: nxt_st.doff_tdd = WDATA_I[2:0];
        `DPT_REG_MEAS: begin
          nxt_st.mcase = dpt_case_e'(WDATA_I[2:0]);
          nxt_st.mreq = WDATA_I[`DPT_MEAS_REQ];
          nxt_st.isref = WDATA_I[`DPT_MEAS_REF];
        end
        `DPT_REG_REF_SFN: nxt_st.ref_sfn = WDATA_I[11:0];
        `DPT_REG_CELL_SFN: nxt_st.cell_sfn = WDATA_I[11:0];
        `DPT_REG_CFN: nxt_st.cfn = WDATA_I[7:0];
        `DPT_REG_REF_RX: nxt_st.ref_rx = WDATA_I[15:0];
        `DPT_REG_CELL_RX: nxt_st.cell_rx = WDATA_I[15:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA_O = st_ff.rdata;
  assign LINK.cfg_valid = st_ff.cfg_valid;
  assign LINK.frame_offset = st_ff.fo;
  assign LINK.chip_offset = st_ff.co;
  assign DOFF_FDD_O = st_ff.doff_fdd;
  assign DOFF_TDD_O = st_ff.doff_tdd;
  assign DOFF_VALID_O = st_ff.doff_valid;

endmodule

`default_nettype wire

// *** dpt_defines.svh ***
// Constants for the dedicated-channel frame and chip offset timing block
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define DPT_FRAME_CHIPS 16'h9600
`define DPT_FRAME_CHIPS_W 24'h00_9600
`define DPT_CHIP_MAX 16'h95FF
`define DPT_POS_WRAP 24'h96_0000
`define DPT_ROUND_HALF 8'h80
`define DPT_ROUND_STEP 16'h0100
`define DPT_DOFF_FDD_MAX 10'h257

// ----------------------------------------------------------------
// Controller register offsets
// ----------------------------------------------------------------
`define DPT_REG_CTRL 8'h00
`define DPT_REG_FO 8'h04
`define DPT_REG_CO 8'h08
`define DPT_REG_DOFF_FDD 8'h0C
`define DPT_REG_DOFF_TDD 8'h10
`define DPT_REG_MEAS 8'h14
`define DPT_REG_REF_SFN 8'h18
`define DPT_REG_CELL_SFN 8'h1C
`define DPT_REG_CFN 8'h20
`define DPT_REG_REF_RX 8'h24
`define DPT_REG_CELL_RX 8'h28
`define DPT_REG_REPORT 8'h2C
`define DPT_REG_STATUS 8'h30
`define DPT_REG_POS 8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DPT_CTRL_SEND 0
`define DPT_CTRL_EVAL 1
`define DPT_CTRL_DCH 2
`define DPT_MEAS_REQ 3
`define DPT_MEAS_REF 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DPT_RST_BYTE 8'h00
`define DPT_RST_HALF 16'h0000
`define DPT_RST_WORD 32'h0000_0000

`endif

// *** dpt_pkg.sv ***
// Types shared by both ends of the offset timing link
package dpt_pkg;

  // ----------------------------------------------------------------
  // Handset reporting cases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DPT_CASE_NONE = 3'b000,
    DPT_CASE_SINGLE = 3'b001,
    DPT_CASE_MULTI = 3'b010,
    DPT_CASE_ADD = 3'b011,
    DPT_CASE_IRAT_ONE = 3'b100,
    DPT_CASE_IRAT_MULTI = 3'b101
  } dpt_case_e;

  // ----------------------------------------------------------------
  // Per-module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fo;
    logic [15:0] co;
    logic [23:0] pos;
    logic [7:0] air_frame;
    logic [15:0] air_chip;
    logic valid;
    logic done;
    logic err;
  } dpt_node_s;

  typedef struct packed {
    logic [7:0] fo;
    logic [15:0] co;
    logic [9:0] doff_fdd;
    logic [2:0] doff_tdd;
    dpt_case_e mcase;
    logic mreq;
    logic isref;
    logic [11:0] ref_sfn;
    logic [11:0] cell_sfn;
    logic [7:0] cfn;
    logic [15:0] ref_rx;
    logic [15:0] cell_rx;
    logic [7:0] off;
    logic off_valid;
    logic [15:0] tm;
    logic cfg_valid;
    logic doff_valid;
    logic [31:0] rdata;
  } dpt_ctrl_s;

endpackage

// *** dpt_if.sv ***
// Link between the offset controller and the base station timing end
`timescale 1ns/1ns
`default_nettype none

interface dpt_if;
  logic cfg_valid;
  logic [7:0] frame_offset;
  logic [15:0] chip_offset;
  logic cfg_done;
  logic cfg_err;
  logic [23:0] pos;

  modport node (
    input cfg_valid,
    input frame_offset,
    input chip_offset,
    output cfg_done,
    output cfg_err,
    output pos
  );

  modport ctrl (
    output cfg_valid,
    output frame_offset,
    output chip_offset,
    input cfg_done,
    input cfg_err,
    input pos
  );
endinterface

`default_nettype wire

// *** dpt_node.sv ***
// Base station end: frame number mapping and rounded chip position
`timescale 1ns/1ns
`default_nettype none
`include "dpt_defines.svh"

// Functional notes
// - Connection frame equals cell frame minus offset
// - Select frame where cell equals connection plus offset
// - Only low eight cell frame bits; wrap 256
// - All three counted in frames, 8-bit range
// - Handset reports frame offset only on request
// - Reported frame offset is 0 to 255
// - Single link entry reports zero offset
// - Several links: zero first, others relative
// - Added link: connection minus target cell frame
// - Other network: own reference cell, others relative
// - FDD default offset 512-chip steps, 0..599
// - TDD default offset whole frames, 0..7
// - Send default offset on entry to dedicated
// - Chip offset one chip, 0 to 38399
// - Position is frame offset*38400 plus chip
// - Remainder 1..127 rounds down
// - Remainder 128..255 rounds up
// - Remainder zero keeps the position
// - 256-chip step for every spreading factor
// - Rounded position sets air transmit timing
// - Chip timing difference always sent, 0..38399
// - Single link entry reports zero chip difference
// - Several links: zero first, others relative
module dpt_node
  import dpt_pkg::*;
(
  input wire logic REF_CLK_I, // System clock
  input wire logic RESET_I, // Synchronous reset, active high
  dpt_if.node LINK, // Offsets from the controller
  input wire logic [11:0] SFN_I, // Current cell frame number
  input wire logic [7:0] CFN_I, // Connection frame from layer two
  output logic [7:0] CFN_O, // Connection frame for layer two
  output logic TX_SEL_O, // Current frame carries CFN_I
  output logic [23:0] POS_O, // Rounded chip position
  output logic [7:0] AIR_FRAME_O, // Air timing, whole frames
  output logic [15:0] AIR_CHIP_O, // Air timing, chips in frame
  output logic POS_VALID_O // Offsets have been accepted
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpt_node_s st_ff;
  dpt_node_s nxt_st;

  logic [7:0] sfn_low;
  logic [7:0] low_bits;
  logic [15:0] co_base;
  logic [15:0] co_round;
  logic [23:0] fo_chips;
  logic [23:0] pos_raw;
  logic [23:0] pos_round;
  logic [23:0] pos_floor;
  logic [7:0] frame_round;
  logic [15:0] chip_round;
  logic co_bad;

  // ----------------------------------------------------------------
  // Frame number mapping
  // ----------------------------------------------------------------
  // Upper cell frame bits play no part in the mapping
  assign sfn_low = SFN_I[7:0];

  // Plain 8-bit arithmetic gives the modulo 256 for free
  assign CFN_O = sfn_low - st_ff.fo;
  assign TX_SEL_O = (sfn_low == (CFN_I + st_ff.fo));

  // ----------------------------------------------------------------
  // Chip position rounding
  // ----------------------------------------------------------------
  assign co_bad = (LINK.chip_offset > `DPT_CHIP_MAX);
  assign low_bits = LINK.chip_offset[7:0];
  assign co_base = {LINK.chip_offset[15:8], 8'h00};

  // A frame is 150 whole steps of 256 chips, so only the chip part
  // of the position can lie off a boundary.
  always_comb begin
    if (low_bits == 8'h00) begin
      co_round = LINK.chip_offset;
    end else if (low_bits < `DPT_ROUND_HALF) begin
      co_round = co_base;
    end else begin
      co_round = co_base + `DPT_ROUND_STEP;
    end
  end

  // Same step whatever the spreading factor, so no such input
  assign fo_chips = 24'(LINK.frame_offset) * `DPT_FRAME_CHIPS_W;
  assign pos_raw = fo_chips + 24'(LINK.chip_offset);
  assign pos_floor = {pos_raw[23:8], 8'h00};

  // Remainder test on the full sum, so the rule reads as written.
  // Rounding up past the last chip of frame 255 wraps to frame zero.
  always_comb begin
    if (pos_raw[7:0] == 8'h00) begin
      pos_round = pos_raw;
    end else if (pos_raw[7:0] < `DPT_ROUND_HALF) begin
      pos_round = pos_floor;
    end else begin
      pos_round = pos_floor + 24'(`DPT_ROUND_STEP);
    end
    frame_round = LINK.frame_offset;
    chip_round = co_round;
    if (co_round == `DPT_FRAME_CHIPS) begin
      frame_round = LINK.frame_offset + 8'h01;
      chip_round = `DPT_RST_HALF;
    end
    if (pos_round == `DPT_POS_WRAP) begin
      pos_round = 24'h00_0000;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Out-of-range chip offsets are refused and the last good timing
  // stays on air, so a bad message never shifts a live channel.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (LINK.cfg_valid) begin
      if (co_bad) begin
        nxt_st.err = 1'b1;
      end else begin
        nxt_st.err = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.valid = 1'b1;
        nxt_st.fo = LINK.frame_offset;
        nxt_st.co = LINK.chip_offset;
        nxt_st.pos = pos_round;
        nxt_st.air_frame = frame_round;
        nxt_st.air_chip = chip_round;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign POS_O = st_ff.pos;
  assign AIR_FRAME_O = st_ff.air_frame;
  assign AIR_CHIP_O = st_ff.air_chip;
  assign POS_VALID_O = st_ff.valid;
  assign LINK.cfg_done = st_ff.done;
  assign LINK.cfg_err = st_ff.err;
  assign LINK.pos = st_ff.pos;

endmodule

`default_nettype wire

// *** dpt_off_assertions.sv ***
// Checker for the offset link between controller and timing end
`timescale 1ns/1ns
`default_nettype none
`include "dpt_defines.svh"

module dpt_off_checker (
  input wire logic REF_CLK_I, // Clock
  input wire logic RESET_I, // Sync reset
  input wire logic cfg_valid, // Offset request
  input wire logic [7:0] frame_offset, // Frames
  input wire logic [15:0] chip_offset, // Chips
  input wire logic cfg_done, // Accepted
  input wire logic cfg_err, // Refused
  input wire logic [23:0] pos // Rounded position
);
  logic [23:0] comb_pos;
  logic [23:0] floor_pos;
  logic good;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  assign comb_pos = frame_offset * `DPT_FRAME_CHIPS_W + 24'(chip_offset);
  assign floor_pos = {comb_pos[23:8], 8'h00};
  assign good = chip_offset <= `DPT_CHIP_MAX;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  sequence good_req;
    cfg_valid && good;
  endsequence
  sequence accepted;
    cfg_done && !cfg_err;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_done_good: assert property (good_req |=> accepted)
    else $error("good offsets not accepted");
  a_err_bad: assert property (cfg_valid && !good |=> cfg_err && !cfg_done)
    else $error("bad chip offset not refused");
  a_round_down: assert property (good_req ##0 comb_pos[7] == 1'b0 |=> pos == $past(floor_pos))
    else $error("low remainder not rounded down");
  a_round_up: assert property (good_req ##0 comb_pos[7] |=>
    pos == ($past(floor_pos) + 24'h00_0100) % `DPT_POS_WRAP)
    else $error("high remainder not rounded up");
  a_round_keep: assert property (good_req ##0 comb_pos[7:0] == 8'h00 |=> pos == $past(comb_pos))
    else $error("aligned position changed");
  a_pos_hold: assert property (!cfg_valid || !good |=> $stable(pos))
    else $error("position moved without good offsets");
  a_step_grid: assert property (pos[7:0] == 8'h00 && pos < `DPT_POS_WRAP)
    else $error("position off the step grid");
  a_done_cause: assert property (cfg_done |-> $past(cfg_valid))
    else $error("done without request");
  a_err_stands: assert property (cfg_err && !cfg_valid |=> cfg_err)
    else $error("refusal flag dropped early");
endmodule

`default_nettype wire

// *** dpt_tb_top.sv ***
// Self-checking bench joining controller and timing end
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module dpt_tb_top;
  import dpt_pkg::*;
  logic clk, rst, wr_s, rd_s, tx_sel, pos_valid, doff_valid;
  logic [7:0] addr, cfn_o, air_frame, cfn;
  logic [31:0] wdata, rdata, v;
  logic [11:0] sfn;
  logic [23:0] pos, exp_pos;
  logic [15:0] air_chip;
  logic [9:0] doff_fdd;
  logic [2:0] doff_tdd;
  int n_errors = 0, cmp_count = 0;
  int tf[8] = '{1, 1, 255, 0, 0, 0, 3, 128};
  int tc[8] = '{200, 100, 38399, 0, 127, 128, 38271, 38399};

  dpt_if link_i();
  dpt_node dpt_node_i(.REF_CLK_I(clk), .RESET_I(rst), .LINK(link_i.node), .SFN_I(sfn),
    .CFN_I(cfn), .CFN_O(cfn_o), .TX_SEL_O(tx_sel), .POS_O(pos), .AIR_FRAME_O(air_frame),
    .AIR_CHIP_O(air_chip), .POS_VALID_O(pos_valid));
  dpt_ctrl dpt_ctrl_i(.REF_CLK_I(clk), .RESET_I(rst), .LINK(link_i.ctrl), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .DOFF_FDD_O(doff_fdd),
    .DOFF_TDD_O(doff_tdd), .DOFF_VALID_O(doff_valid));
  dpt_off_checker dpt_off_checker_i(.REF_CLK_I(clk), .RESET_I(rst),
    .cfg_valid(link_i.cfg_valid), .frame_offset(link_i.frame_offset),
    .chip_offset(link_i.chip_offset), .cfg_done(link_i.cfg_done),
    .cfg_err(link_i.cfg_err), .pos(link_i.pos));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and model
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [23:0] rnd(input int f, input int c);
    int p;
    p = f * 38400 + c;
    p = ((p + 128) / 256) * 256;
    return 24'(p % 9830400);
  endfunction

  task automatic cfg(input int f, input int c);
    int i;
    wr(8'h04, 32'(f));
    wr(8'h08, 32'(c));
    wr(8'h00, 32'h0000_0001);
    i = 0;
    do begin
      @(posedge clk) #1;
      i++;
    end while (!(link_i.cfg_done || link_i.cfg_err) && i < 10);
    if (i >= 10) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // Checks frame mapping at the current offset, in the same cycle
  task automatic map_chk(input int f, input bit hit);
    logic [11:0] s;
    logic [7:0] c;
    s = 12'($urandom);
    c = hit ? 8'(s[7:0] - 8'(f)) : 8'($urandom);
    @(posedge clk);
    sfn <= s;
    cfn <= c;
    #1 `CHK("cfn_o", 8'(s[7:0] - 8'(f)), cfn_o)
    `CHK("tx_sel", 1'(((c + f) % 256) == s[7:0]), tx_sel)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int k, f, c, mc, o, tm;
    logic rq, isr;
    logic [7:0] cf;
    logic [11:0] rs, cs;
    logic [15:0] rr, cr;
    rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    sfn = 12'h000; cfn = 8'h00;
    void'($urandom(32'h18a4));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK("pos rst", 24'h00_0000, pos)
    `CHK("valid rst", 1'b0, pos_valid)
    rd(8'h30, v);
    `CHK("status rst", 32'h0000_0000, v)
    $display("test reset done");
    for (k = 0; k < 14; k++) begin
      f = (k < 8) ? tf[k] : int'($urandom % 256);
      c = (k < 8) ? tc[k] : int'($urandom % 38400);
      exp_pos = rnd(f, c);
      cfg(f, c);
      `CHK("pos", exp_pos, pos)
      `CHK("air frame", 8'(exp_pos / 38400), air_frame)
      `CHK("air chip", 16'(exp_pos % 38400), air_chip)
      `CHK("valid", 1'b1, pos_valid)
      rd(8'h34, v);
      `CHK("pos reg", 32'(exp_pos), v)
      map_chk(f, k[0]);
    end
    $display("test rounding and mapping done");
    cfg(9, 38400);
    `CHK("err", 1'b1, link_i.cfg_err)
    `CHK("pos kept", exp_pos, pos)
    map_chk(f, 1'b1);
    rd(8'h30, v);
    `CHK("status err", 1'b1, v[0])
    cfg(4, 5);
    `CHK("err cleared", 1'b0, link_i.cfg_err)
    `CHK("pos next", rnd(4, 5), pos)
    rd(8'h04, v);
    `CHK("fo reg", 32'h0000_0004, v)
    rd(8'h08, v);
    `CHK("co reg", 32'h0000_0005, v)
    $display("test refusal done");
    for (k = 0; k < 16; k++) begin
      mc = k % 8; rq = k[3]; isr = 1'($urandom);
      rs = 12'($urandom); cs = 12'($urandom); cf = 8'($urandom);
      rr = 16'($urandom % 38400); cr = 16'($urandom % 38400);
      wr(8'h14, {27'h0, isr, rq, 3'(mc)}); wr(8'h18, 32'(rs)); wr(8'h1C, 32'(cs));
      wr(8'h20, 32'(cf)); wr(8'h24, 32'(rr)); wr(8'h28, 32'(cr)); wr(8'h00, 32'h0000_0002);
      o = 0; tm = 0;
      if ((mc == 2 || mc == 5) && !isr) begin
        o = (cs - rs) & 255; tm = (cr + 38400 - rr) % 38400;
      end
      if (mc == 3) begin
        o = (cf - cs) & 255; tm = (cr + 38400 - rr) % 38400;
      end
      rd(8'h2C, v);
      `CHK("report", {16'(tm), 7'h00, rq && mc > 0 && mc < 6, 8'(o)}, v)
    end
    $display("test reports done");
    wr(8'h0C, 32'd599); wr(8'h0C, 32'd600); wr(8'h10, 32'd7); wr(8'h00, 32'h0000_0004);
    #1 `CHK("doff pulse", 1'b1, doff_valid)
    `CHK("doff fdd", 10'd599, doff_fdd)
    `CHK("doff tdd", 3'd7, doff_tdd)
    @(posedge clk) #1 `CHK("doff end", 1'b0, doff_valid)
    rd(8'h0C, v);
    `CHK("doff fdd reg", 32'h0000_0257, v)
    rd(8'h10, v);
    `CHK("doff tdd reg", 32'h0000_0007, v)
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, v);
    `CHK("unmapped", 32'h0000_0000, v)
    rd(8'h00, v);
    `CHK("ctrl read", 32'h0000_0000, v)
    $display("test defaults and map done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK("pos rst2", 24'h00_0000, pos)
    `CHK("air rst2", 8'h00, air_frame)
    `CHK("valid rst2", 1'b0, pos_valid)
    `CHK("tdd rst2", 3'h0, doff_tdd)
    map_chk(0, 1'b1);
    $display("test mid reset done");
    give_verdict();
  end
endmodule

`default_nettype wire
